// >>> rtl/otg_neg_pkg.sv
// Purpose: shared constants and carriers for the session negotiation register block
// Assumes: 32-bit word-aligned registers on a simple register port
// Notes: offsets are byte addresses
package otg_neg_pkg;

    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_EVT = 12'h004;
    localparam logic [11:0] OFS_BUSCFG = 12'h008;
    localparam logic [11:0] OFS_PWR = 12'he00;

    // ****************************************************************
    // control/status field positions
    // ****************************************************************
    localparam int CTL_REQ_OK = 0;
    localparam int CTL_SES_REQ = 1;
    localparam int CTL_VB_EN = 2;
    localparam int CTL_VB_VAL = 3;
    localparam int CTL_AV_EN = 4;
    localparam int CTL_AV_VAL = 5;
    localparam int CTL_BV_EN = 6;
    localparam int CTL_BV_VAL = 7;
    localparam int CTL_SWAP_OK = 8;
    localparam int CTL_SWAP_REQ = 9;
    localparam int CTL_HOST_SWAP_EN = 10;
    localparam int CTL_DEV_SWAP_EN = 11;
    localparam int CTL_CONN_ID = 16;
    localparam int CTL_DEBOUNCE = 17;
    localparam int CTL_A_SES = 18;
    localparam int CTL_B_SES = 19;
    localparam int CTL_REV = 20;

    // ****************************************************************
    // event flag field positions
    // ****************************************************************
    localparam int EVT_SES_END = 2;
    localparam int EVT_REQ_DONE = 8;
    localparam int EVT_SWAP_DONE = 9;
    localparam int EVT_SWAP_DET = 17;
    localparam int EVT_DBNC_DONE = 19;
    localparam int EVT_ADEV_TOUT = 18;

    // ****************************************************************
    // writable masks and bus config
    // ****************************************************************
    localparam logic [31:0] CTL_RW_MASK = 32'h0010_0cfc;
    localparam logic [31:0] BUSCFG_RW_MASK = 32'h007f_ffbf;
    localparam logic [31:0] BUSCFG_RESET = 32'h0000_0040;
    localparam logic [31:0] PWR_RW_MASK = 32'h0000_000f;
    localparam int BUS_ADDR_W = 12;
    localparam int SHADOW_WORDS = 4;

    typedef struct packed {
        logic b_valid;
        logic a_valid;
        logic vbus_ok;
        logic conn_id;
        logic debounce_short;
    } phy_status_s;

    typedef struct packed {
        logic swap_detected;
        logic swap_done;
        logic swap_success;
        logic req_done;
        logic req_success;
        logic dbnc_done;
        logic adev_tout;
    } neg_events_s;

    typedef struct packed {
        logic b_valid;
        logic a_valid;
        logic vbus_ok;
        logic session_request;
        logic swap_request;
        logic swap_enable;
        logic data_line_only;
    } neg_ctrl_s;

endpackage

// >>> rtl/otg_neg_shadow_ram.sv
// Purpose: small word store for config registers that survive role changes
// Assumes: one write and one read port, registered read data
// Notes: not cleared by role change; reset_n loads the reset values and only writes change them
`timescale 1ns/100ps
module otg_neg_shadow_ram
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic wr_en,
    input wire logic [1:0] wr_idx,
    input wire logic [31:0] wr_data,
    input wire logic [31:0] wr_mask,
    input wire logic [1:0] rd_idx,
    output logic [31:0] rd_data_ff
);

    logic [31:0] mem_ff [otg_neg_pkg::SHADOW_WORDS];

    // ****************************************************************
    // storage, masked write
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < otg_neg_pkg::SHADOW_WORDS; gi++)
        begin : g_word
            always_ff @(posedge clk_sys or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    mem_ff[gi] <= (gi == 2) ? otg_neg_pkg::BUSCFG_RESET : 32'h0000_0000;
                end
                else if (wr_en && (wr_idx == 2'(gi)))
                begin
                    mem_ff[gi] <= (mem_ff[gi] & ~wr_mask) | (wr_data & wr_mask);
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rd_data_ff <= 32'h0000_0000;
        end
        else
        begin
            rd_data_ff <= mem_ff[rd_idx];
        end
    end

endmodule

// >>> rtl/otg_session_negotiation_csr.sv
// Purpose: control/status and event registers for session and role negotiation
// Assumes: simple AHB-side register port, one access per cycle, read data one cycle late
// Notes: registers keep contents across role changes; role input only gates meaning
`timescale 1ns/100ps
module otg_session_negotiation_csr
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic reg_sel,
    input wire logic reg_write,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_ready,
    input wire logic host_role,
    input wire otg_neg_pkg::phy_status_s phy_status,
    input wire otg_neg_pkg::neg_events_s neg_events,
    output otg_neg_pkg::neg_ctrl_s neg_ctrl
);

    // ****************************************************************
    // decode
    // ****************************************************************
    logic wr_ctrl;
    logic wr_evt;
    logic wr_shadow;
    logic hit_ctrl;
    logic hit_evt;
    logic hit_cfg;
    logic hit_pwr;
    logic [1:0] shadow_idx;
    logic [31:0] shadow_mask;

    always_comb
    begin
        hit_ctrl = (reg_addr == otg_neg_pkg::OFS_CTRL);
        hit_evt = (reg_addr == otg_neg_pkg::OFS_EVT);
        hit_cfg = (reg_addr == otg_neg_pkg::OFS_BUSCFG);
        hit_pwr = (reg_addr == otg_neg_pkg::OFS_PWR);
    end

    assign wr_ctrl = reg_sel && reg_write && hit_ctrl;
    assign wr_evt = reg_sel && reg_write && hit_evt;
    assign wr_shadow = reg_sel && reg_write && (hit_cfg || hit_pwr);
    assign shadow_idx = hit_pwr ? 2'd3 : 2'd2;
    assign shadow_mask = hit_pwr ? otg_neg_pkg::PWR_RW_MASK : otg_neg_pkg::BUSCFG_RW_MASK;
    assign reg_ready = 1'b1;

    // ****************************************************************
    // plain control bits
    // ****************************************************************
    logic [31:0] ctl_ff;

    // no reset on role change, kept across roles
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctl_ff <= 32'h0000_0000;
        end
        else if (wr_ctrl)
        begin
            ctl_ff <= reg_wdata & otg_neg_pkg::CTL_RW_MASK;
        end
    end

    // ****************************************************************
    // request bits
    // ****************************************************************
    logic ses_req_ff;
    logic swap_req_ff;
    logic [31:0] evt_ff;

    // session request set by one, cleared by a control write with that bit zero while swap-done flag set, or by request done while that flag is clear
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ses_req_ff <= 1'b0;
        end
        else if (wr_ctrl && reg_wdata[otg_neg_pkg::CTL_SES_REQ])
        begin
            ses_req_ff <= 1'b1;
        end
        else if (wr_ctrl && evt_ff[otg_neg_pkg::EVT_SWAP_DONE])
        begin
            ses_req_ff <= 1'b0;
        end
        else if (neg_events.req_done && !evt_ff[otg_neg_pkg::EVT_SWAP_DONE])
        begin
            ses_req_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            swap_req_ff <= 1'b0;
        end
        else if (wr_ctrl && reg_wdata[otg_neg_pkg::CTL_SWAP_REQ])
        begin
            swap_req_ff <= 1'b1;
        end
        else if (wr_ctrl && evt_ff[otg_neg_pkg::EVT_SWAP_DONE])
        begin
            swap_req_ff <= 1'b0;
        end
        else if (neg_events.swap_done && !evt_ff[otg_neg_pkg::EVT_SWAP_DONE])
        begin
            swap_req_ff <= 1'b0;
        end
    end

    // ****************************************************************
    // outcome status
    // ****************************************************************
    logic swap_ok_ff;
    logic req_ok_ff;

    // hardware sets and clears, software one clears
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            swap_ok_ff <= 1'b0;
        end
        else if (neg_events.swap_done)
        begin
            swap_ok_ff <= neg_events.swap_success;
        end
        else if (wr_ctrl && reg_wdata[otg_neg_pkg::CTL_SWAP_OK])
        begin
            swap_ok_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            req_ok_ff <= 1'b0;
        end
        else if (neg_events.req_done)
        begin
            req_ok_ff <= neg_events.req_success;
        end
        else if (wr_ctrl && reg_wdata[otg_neg_pkg::CTL_REQ_OK])
        begin
            req_ok_ff <= 1'b0;
        end
    end

    // ****************************************************************
    // effective valid signals
    // ****************************************************************
    logic b_valid_eff;
    logic a_valid_eff;
    logic vbus_ok_eff;
    logic b_valid_d_ff;

    assign b_valid_eff = ctl_ff[otg_neg_pkg::CTL_BV_EN] ? ctl_ff[otg_neg_pkg::CTL_BV_VAL]
                                                        : phy_status.b_valid;
    assign a_valid_eff = (ctl_ff[otg_neg_pkg::CTL_AV_EN] && host_role)
                         ? ctl_ff[otg_neg_pkg::CTL_AV_VAL] : phy_status.a_valid;
    assign vbus_ok_eff = (ctl_ff[otg_neg_pkg::CTL_VB_EN] && host_role)
                         ? ctl_ff[otg_neg_pkg::CTL_VB_VAL] : phy_status.vbus_ok;

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            b_valid_d_ff <= 1'b1;
        end
        else
        begin
            b_valid_d_ff <= b_valid_eff;
        end
    end

    // ****************************************************************
    // event flags
    // ****************************************************************
    logic [31:0] evt_set;

    always_comb
    begin
        evt_set = 32'h0000_0000;
        evt_set[otg_neg_pkg::EVT_SWAP_DET] = neg_events.swap_detected;
        evt_set[otg_neg_pkg::EVT_SWAP_DONE] = neg_events.swap_done;
        evt_set[otg_neg_pkg::EVT_REQ_DONE] = neg_events.req_done;
        evt_set[otg_neg_pkg::EVT_SES_END] = b_valid_d_ff && !b_valid_eff && !host_role;
        evt_set[otg_neg_pkg::EVT_DBNC_DONE] = neg_events.dbnc_done;
        evt_set[otg_neg_pkg::EVT_ADEV_TOUT] = neg_events.adev_tout;
    end

    // set wins over write-one clear; zero writes keep
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            evt_ff <= 32'h0000_0000;
        end
        else
        begin
            evt_ff <= evt_set | (evt_ff & ~(wr_evt ? reg_wdata : 32'h0000_0000));
        end
    end

    // ****************************************************************
    // configuration words kept in the shadow store
    // ****************************************************************
    logic [31:0] shadow_rdata;

    // stored under the write mask; kept across role changes without a rewrite
    otg_neg_shadow_ram u_shadow
    (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .wr_en(wr_shadow),
        .wr_idx(shadow_idx),
        .wr_data(reg_wdata),
        .wr_mask(shadow_mask),
        .rd_idx(shadow_idx),
        .rd_data_ff(shadow_rdata)
    );

    // ****************************************************************
    // read path
    // ****************************************************************
    logic [31:0] ctl_view;
    logic [31:0] nxt_rdata;
    logic [31:0] rdata_ff;
    logic sel_shadow_ff;

    always_comb
    begin
        ctl_view = ctl_ff;
        ctl_view[otg_neg_pkg::CTL_REQ_OK] = req_ok_ff;
        ctl_view[otg_neg_pkg::CTL_SES_REQ] = ses_req_ff;
        ctl_view[otg_neg_pkg::CTL_SWAP_OK] = swap_ok_ff;
        ctl_view[otg_neg_pkg::CTL_SWAP_REQ] = swap_req_ff;
        ctl_view[otg_neg_pkg::CTL_CONN_ID] = phy_status.conn_id;
        ctl_view[otg_neg_pkg::CTL_DEBOUNCE] = phy_status.debounce_short;
        ctl_view[otg_neg_pkg::CTL_A_SES] = host_role && a_valid_eff;
        ctl_view[otg_neg_pkg::CTL_B_SES] = b_valid_eff;
    end

    always_comb
    begin
        nxt_rdata = 32'h0000_0000;
        if (hit_ctrl)
        begin
            nxt_rdata = ctl_view;
        end
        else if (hit_evt)
        begin
            nxt_rdata = evt_ff;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rdata_ff <= 32'h0000_0000;
            sel_shadow_ff <= 1'b0;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
            sel_shadow_ff <= reg_sel && (hit_cfg || hit_pwr);
        end
    end

    assign reg_rdata = sel_shadow_ff ? shadow_rdata : rdata_ff;

    // ****************************************************************
    // outputs to negotiation logic
    // ****************************************************************
    // revision picks pulsing method
    assign neg_ctrl.data_line_only = ctl_ff[otg_neg_pkg::CTL_REV];
    assign neg_ctrl.b_valid = b_valid_eff;
    assign neg_ctrl.a_valid = a_valid_eff;
    assign neg_ctrl.vbus_ok = vbus_ok_eff;
    // request bits cleared only by controller logic above
    assign neg_ctrl.session_request = ses_req_ff;
    assign neg_ctrl.swap_request = swap_req_ff;
    assign neg_ctrl.swap_enable = host_role ? ctl_ff[otg_neg_pkg::CTL_HOST_SWAP_EN]
                                            : ctl_ff[otg_neg_pkg::CTL_DEV_SWAP_EN];

    // ****************************************************************
    // checks
    // ****************************************************************
    AST_EVT_SET_WINS: assert property (@(posedge clk_sys) disable iff (!reset_n)
        neg_events.swap_done |=> evt_ff[otg_neg_pkg::EVT_SWAP_DONE])
        else $error("completion flag lost");
    AST_ZERO_KEEPS: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (wr_evt && !reg_wdata[otg_neg_pkg::EVT_SES_END] && evt_ff[otg_neg_pkg::EVT_SES_END])
        |=> evt_ff[otg_neg_pkg::EVT_SES_END])
        else $error("zero write cleared flag");
    AST_SES_END: assert property (@(posedge clk_sys) disable iff (!reset_n)
        ($fell(b_valid_eff) && !host_role) |=> evt_ff[otg_neg_pkg::EVT_SES_END])
        else $error("session end not flagged");
    AST_BV_OVR: assert property (@(posedge clk_sys) disable iff (!reset_n)
        ctl_ff[otg_neg_pkg::CTL_BV_EN] |-> neg_ctrl.b_valid == ctl_ff[otg_neg_pkg::CTL_BV_VAL])
        else $error("b valid override ignored");
    AST_SES_REQ_SET: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (wr_ctrl && reg_wdata[otg_neg_pkg::CTL_SES_REQ]) |=> ses_req_ff)
        else $error("session request not set");
    AST_SWAP_OK: assert property (@(posedge clk_sys) disable iff (!reset_n)
        neg_events.swap_done |=> swap_ok_ff == $past(neg_events.swap_success))
        else $error("swap outcome wrong");
    AST_REV: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (wr_ctrl && reg_wdata[otg_neg_pkg::CTL_REV]) |=> neg_ctrl.data_line_only)
        else $error("revision not applied");
    AST_REQ_DONE: assert property (@(posedge clk_sys) disable iff (!reset_n)
        neg_events.req_done |=> evt_ff[otg_neg_pkg::EVT_REQ_DONE])
        else $error("request done not flagged");

endmodule

// >>> sim/otg_peer_model.sv
// Purpose: far-side model of the transceiver and the remote negotiating peer
// Assumes: status lines are levels, events are one-cycle pulses at the rising edge
// Notes: the bench commands it through its tasks; it never answers on its own
`timescale 1ns/100ps
module otg_peer_model
(
    input wire logic clk_sys,
    output otg_neg_pkg::phy_status_s phy_status,
    output otg_neg_pkg::neg_events_s neg_events
);
    // ****************************************************************
    // transceiver levels
    // ****************************************************************
    // b-session valid and b-device identity at power-on
    initial
    begin
        phy_status = otg_neg_pkg::phy_status_s'(5'h12);
        neg_events = otg_neg_pkg::neg_events_s'(7'h00);
    end

    // a drop of b_valid here marks session end in the device role
    task automatic set_phy(input otg_neg_pkg::phy_status_s s);
        phy_status <= s;
    endtask

    // ****************************************************************
    // negotiation outcomes
    // ****************************************************************
    // one-cycle pulse, outcome qualifies the done pulse
    task automatic fire(input otg_neg_pkg::neg_events_s e);
        @(posedge clk_sys);
        neg_events <= e;
        @(posedge clk_sys);
        neg_events <= otg_neg_pkg::neg_events_s'(7'h00);
    endtask
endmodule

// >>> sim/otg_session_negotiation_csr_tb.sv
// Purpose: self-checking bench for the session negotiation register block
// Assumes: one access per cycle, read data one cycle after the access edge
// Notes: expected read words are queued by the driver and checked by a monitor
`timescale 1ns/100ps
module otg_session_negotiation_csr_tb;
    logic clk_sys;
    logic reset_n;
    logic reg_sel;
    logic reg_write;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata;
    logic host_role;
    wire logic [31:0] reg_rdata;
    wire logic reg_ready;
    otg_neg_pkg::phy_status_s phy_status;
    otg_neg_pkg::neg_events_s neg_events;
    otg_neg_pkg::neg_ctrl_s neg_ctrl;
    int fail_count;
    int samples_checked;
    logic [31:0] exp_q[$];
    logic [6:0] ev_tab[7] = '{7'h40, 7'h30, 7'h20, 7'h0c, 7'h08, 7'h02, 7'h01};
    int eb_tab[7] = '{17, 9, 9, 8, 8, 19, 18};
    logic [31:0] ok_tab[7] = '{32'h0, 32'h100, 32'h0, 32'h1, 32'h0, 32'h0, 32'h0};

    otg_session_negotiation_csr i_otg_session_negotiation_csr
    (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .reg_sel(reg_sel),
        .reg_write(reg_write),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .reg_ready(reg_ready),
        .host_role(host_role),
        .phy_status(phy_status),
        .neg_events(neg_events),
        .neg_ctrl(neg_ctrl)
    );

    otg_peer_model i_otg_peer_model
    (
        .clk_sys(clk_sys),
        .phy_status(phy_status),
        .neg_events(neg_events)
    );

    initial
    begin
        clk_sys = 1'h0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // ****************************************************************
    // bus tasks and compares
    // ****************************************************************
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        reg_sel <= 1'h1;
        reg_write <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        reg_sel <= 1'h1;
        reg_write <= 1'h0;
        reg_addr <= a;
        @(posedge clk_sys);
    endtask

    task automatic idle();
        reg_sel <= 1'h0;
        @(posedge clk_sys);
    endtask

    task automatic cmp_rd(input logic [31:0] e);
        samples_checked++;
        if (reg_rdata !== e || reg_ready !== 1'h1)
        begin
            fail_count++;
            $display("Error at %0t: read %h expected %h", $time, reg_rdata, e);
        end
    endtask

    task automatic chk_ctl(input otg_neg_pkg::neg_ctrl_s e);
        samples_checked++;
        if (neg_ctrl !== e)
        begin
            fail_count++;
            $display("Error at %0t: control out %h expected %h", $time, neg_ctrl, e);
        end
    endtask

    function automatic logic [31:0] live();
        live = {12'h0, phy_status.b_valid, phy_status.a_valid & host_role,
                phy_status.debounce_short, phy_status.conn_id, 16'h0};
    endfunction

    task automatic results();
        if (fail_count == 0 && samples_checked > 0)
        begin
            $display("TEST PASSED");
        end
        else
        begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // read monitor: oldest note against the word one cycle after the access
    initial
    begin
        forever
        begin
            @(posedge clk_sys);
            if (reg_sel === 1'h1 && reg_write === 1'h0 && exp_q.size() > 0)
            begin
                #1;
                cmp_rd(exp_q.pop_front());
            end
        end
    end

    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial
    begin
        logic [31:0] w;
        logic [31:0] bc_sh;
        logic [31:0] b;
        otg_neg_pkg::phy_status_s ps;
        otg_neg_pkg::neg_ctrl_s e;
        reset_n = 1'h0;
        reg_sel = 1'h0;
        reg_write = 1'h0;
        reg_addr = 12'h000;
        reg_wdata = 32'h0;
        host_role = 1'h0;
        fail_count = 0;
        samples_checked = 0;
        void'($urandom(32'h463c));
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'h1;
        @(posedge clk_sys);
        rd(otg_neg_pkg::OFS_CTRL, 32'h0009_0000);
        rd(otg_neg_pkg::OFS_EVT, 32'h0);
        rd(otg_neg_pkg::OFS_BUSCFG, otg_neg_pkg::BUSCFG_RESET);
        rd(otg_neg_pkg::OFS_PWR, 32'h0);
        w = $urandom;
        bc_sh = (w & otg_neg_pkg::BUSCFG_RW_MASK) | otg_neg_pkg::BUSCFG_RESET;
        wr(otg_neg_pkg::OFS_BUSCFG, w);
        wr(otg_neg_pkg::OFS_PWR, ~w);
        wr(12'h00c, w);
        rd(otg_neg_pkg::OFS_BUSCFG, bc_sh);
        rd(otg_neg_pkg::OFS_PWR, ~w & otg_neg_pkg::PWR_RW_MASK);
        rd(12'h00c, 32'h0);
        // overrides, revision bit and role changes over random levels
        for (int i = 0; i < 16; i++)
        begin
            ps = otg_neg_pkg::phy_status_s'(5'($urandom));
            w = $urandom & ~32'h0000_0303;
            host_role <= i[0];
            i_otg_peer_model.set_phy(ps);
            wr(otg_neg_pkg::OFS_CTRL, w);
            idle();
            e.b_valid = w[6] ? w[7] : ps.b_valid;
            e.a_valid = (i[0] && w[4]) ? w[5] : ps.a_valid;
            e.vbus_ok = (i[0] && w[2]) ? w[3] : ps.vbus_ok;
            e.session_request = 1'h0;
            e.swap_request = 1'h0;
            e.swap_enable = i[0] ? w[10] : w[11];
            e.data_line_only = w[20];
            chk_ctl(e);
            b = {12'h0, e.b_valid, i[0] & e.a_valid, ps.debounce_short, ps.conn_id, 16'h0};
            rd(otg_neg_pkg::OFS_CTRL, (w & otg_neg_pkg::CTL_RW_MASK) | b);
            rd(otg_neg_pkg::OFS_BUSCFG, bc_sh);
        end
        i_otg_peer_model.set_phy(otg_neg_pkg::phy_status_s'(5'h12));
        wr(otg_neg_pkg::OFS_CTRL, 32'h0);
        wr(otg_neg_pkg::OFS_EVT, 32'hffff_ffff);
        rd(otg_neg_pkg::OFS_EVT, 32'h0);
        // session end only counts in the device role
        for (int r = 0; r < 2; r++)
        begin
            host_role <= r[0];
            i_otg_peer_model.set_phy(otg_neg_pkg::phy_status_s'(5'h02));
            idle();
            idle();
            rd(otg_neg_pkg::OFS_EVT, (r == 0) ? 32'h4 : 32'h0);
            wr(otg_neg_pkg::OFS_EVT, 32'h4);
            i_otg_peer_model.set_phy(otg_neg_pkg::phy_status_s'(5'h12));
            idle();
        end
        // every neg_events source, outcome latch and write-one clear
        for (int k = 0; k < 7; k++)
        begin
            idle();
            i_otg_peer_model.fire(otg_neg_pkg::neg_events_s'(ev_tab[k]));
            b = 32'h1 << eb_tab[k];
            rd(otg_neg_pkg::OFS_EVT, b);
            rd(otg_neg_pkg::OFS_CTRL, live() | ok_tab[k]);
            wr(otg_neg_pkg::OFS_EVT, ~b);
            rd(otg_neg_pkg::OFS_EVT, b);
            wr(otg_neg_pkg::OFS_EVT, b);
            rd(otg_neg_pkg::OFS_EVT, 32'h0);
        end
        // software requests reach the negotiation logic
        wr(otg_neg_pkg::OFS_EVT, 32'hffff_ffff);
        wr(otg_neg_pkg::OFS_CTRL, 32'h0000_0202);
        idle();
        chk_ctl(otg_neg_pkg::neg_ctrl_s'(7'h4c));
        rd(otg_neg_pkg::OFS_CTRL, live() | 32'h0000_0202);
        idle();
        repeat (3) @(posedge clk_sys);
        if (exp_q.size() != 0)
        begin
            fail_count++;
            $display("Error at %0t: read results missing", $time);
        end
        results();
    end
endmodule
